// ===== asf_regs.svh
// Constants of the serial audio frame receiver
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH

// Slot-mode field encodings
`define ASF_SLOT_NORMAL     2'h0
`define ASF_SLOT_128        2'h1
`define ASF_SLOT_256        2'h2
`define ASF_SLOT_512        2'h3

// Bit-clock periods per frame in the slotted modes
`define ASF_FRAME_BITS_128  10'h080
`define ASF_FRAME_BITS_256  10'h100
`define ASF_FRAME_BITS_512  10'h200

// Largest bit-clock to frame ratio in non-multiplexed framing
`define ASF_RATIO_NORM      10'h100
`define ASF_RATIO_DOUBLE    10'h080
`define ASF_RATIO_QUAD      10'h040

// Speed-select field bits that pick the faster modes
`define ASF_SPD_QUAD_BIT    2
`define ASF_SPD_DOUBLE_BIT  1

// Slot word layout
`define ASF_WORD_BITS       32
`define ASF_SLOT_BITS       4
`define ASF_WORD_LAST       5'h1F
`define ASF_CNT_FIRST       10'h001
`define ASF_CNT_ZERO        10'h000
`define ASF_CNT_SAT         10'h3FF

// Frame-rate limits in Hz and the system clock rate
`define ASF_SYS_CLK_HZ      250000000
`define ASF_FS_NORM_MIN_HZ  8000
`define ASF_FS_NORM_MAX_HZ  48000
`define ASF_FS_DBL_MIN_HZ   48000
`define ASF_FS_DBL_MAX_HZ   96000
`define ASF_FS_QUAD_MIN_HZ  96000
`define ASF_FS_QUAD_MAX_HZ  192000
`define ASF_RATE_TOL_CYC    16'h0008

// Shortest frame period rounds up, longest rounds down
`define ASF_MIN_CYC(hz)     ((`ASF_SYS_CLK_HZ + (hz) - 1) / (hz))
`define ASF_MAX_CYC(hz)     (`ASF_SYS_CLK_HZ / (hz))

`endif

// ===== asf_pkg.sv
// Types and shared decode functions of the serial audio frame receiver
`include "asf_regs.svh"

package asf_pkg;

    typedef enum logic [2:0] {
        ASF_SPD_NORMAL = 3'b001,
        ASF_SPD_DOUBLE = 3'b010,
        ASF_SPD_QUAD   = 3'b100
    } asf_speed_t;

    typedef enum logic [1:0] {
        ASF_LS_SEEK = 2'b01,
        ASF_LS_RUN  = 2'b10
    } asf_lstate_t;

    // Faster mode wins when several select bits are set
    function automatic asf_speed_t asf_speed_decode(input logic [2:0] sel);
        if (sel[`ASF_SPD_QUAD_BIT])
            return ASF_SPD_QUAD;
        else if (sel[`ASF_SPD_DOUBLE_BIT])
            return ASF_SPD_DOUBLE;
        return ASF_SPD_NORMAL;
    endfunction

    function automatic logic [9:0] asf_ratio_limit(input asf_speed_t spd);
        if (spd == ASF_SPD_QUAD)
            return `ASF_RATIO_QUAD;
        else if (spd == ASF_SPD_DOUBLE)
            return `ASF_RATIO_DOUBLE;
        return `ASF_RATIO_NORM;
    endfunction

    function automatic logic [9:0] asf_frame_bits(input logic [1:0] slot);
        if (slot == `ASF_SLOT_512)
            return `ASF_FRAME_BITS_512;
        else if (slot == `ASF_SLOT_256)
            return `ASF_FRAME_BITS_256;
        return `ASF_FRAME_BITS_128;
    endfunction

    // Slotted frames of 256 drop quad speed, 512 allow normal only
    function automatic logic asf_mode_legal(input logic [1:0] slot, input asf_speed_t spd);
        if (slot == `ASF_SLOT_512)
            return spd == ASF_SPD_NORMAL;
        else if (slot == `ASF_SLOT_256)
            return spd != ASF_SPD_QUAD;
        return 1'h1;
    endfunction

endpackage

// ===== asf_buf2.sv
// Two-entry word buffer with registered output
`timescale 1ns/10ps
`default_nettype none

module asf_buf2
#(
    parameter int W = 36
)
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);

    logic [1:0]   cnt_q;
    logic [1:0]   cnt_d;
    logic [W-1:0] tail_q;
    logic         full_q;
    logic         push_w;
    logic         pop_w;

    // Head lives in out_data so the reader sees a flop
    assign in_ready = ~full_q;
    assign push_w   = in_valid & ~full_q;
    assign pop_w    = out_valid & out_ready;
    assign cnt_d    = cnt_q + {1'h0, push_w} - {1'h0, pop_w};

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q     <= 2'h0;
            full_q    <= 1'h0;
            out_valid <= 1'h0;
        end
        else
        begin
            cnt_q     <= cnt_d;
            full_q    <= cnt_d == 2'h2;
            out_valid <= cnt_d != 2'h0;
        end
    end

    // Head refills from the tail, or straight from the input when the tail is empty
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_data <= '0;
            tail_q   <= '0;
        end
        else
        begin
            if ((pop_w && cnt_q == 2'h2))
                out_data <= tail_q;
            else if (push_w && (cnt_q == 2'h0 || (pop_w && cnt_q == 2'h1)))
                out_data <= in_data;
            if (push_w && ((cnt_q == 2'h1 && !pop_w) || (cnt_q == 2'h2 && pop_w)))
                tail_q <= in_data;
        end
    end

endmodule

`default_nettype wire

// ===== asf_frame_rx.sv
// Serial audio input port: frame timing, slot words and format checks
// Notes on behaviour
// - Non-multiplexed frames hold at most 256, 128 or 64 bits by speed.
// - Slot mode 01: 128-bit frames, any speed, each clock phase one bit or more.
// - Slot mode 10: 256-bit frames, normal or double speed only.
// - Slot mode 11: 512-bit frames, normal speed only.
// - Speed mode comes from the speed-select field and picks the limits.
`timescale 1ns/10ps
`default_nettype none
`include "asf_regs.svh"

module asf_frame_rx
    import asf_pkg::*;
#(
    parameter logic [15:0] FR_MIN_NORM = 16'(`ASF_MIN_CYC(`ASF_FS_NORM_MAX_HZ)),
    parameter logic [15:0] FR_MAX_NORM = 16'(`ASF_MAX_CYC(`ASF_FS_NORM_MIN_HZ)),
    parameter logic [15:0] FR_MIN_DBL  = 16'(`ASF_MIN_CYC(`ASF_FS_DBL_MAX_HZ)),
    parameter logic [15:0] FR_MAX_DBL  = 16'(`ASF_MAX_CYC(`ASF_FS_DBL_MIN_HZ)),
    parameter logic [15:0] FR_MIN_QUAD = 16'(`ASF_MIN_CYC(`ASF_FS_QUAD_MAX_HZ)),
    parameter logic [15:0] FR_MAX_QUAD = 16'(`ASF_MAX_CYC(`ASF_FS_QUAD_MIN_HZ)),
    parameter logic [15:0] RATE_TOL    = `ASF_RATE_TOL_CYC
)
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst_b,
    input  wire logic                      bit_clock,
    input  wire logic                      frame_clock,
    input  wire logic                      serial_audio_in,
    input  wire logic [1:0]                slot_mode,
    input  wire logic [2:0]                speed_select,
    output logic [`ASF_WORD_BITS-1:0]      word_data,
    output logic [`ASF_SLOT_BITS-1:0]      word_slot,
    output logic                           word_valid,
    input  wire logic                      word_ready,
    output logic                           frame_start_q,
    output logic                           ratio_err_q,
    output logic                           mode_err_q,
    output logic                           rate_err_q,
    output logic                           overrun_q
);

    localparam int BW = `ASF_WORD_BITS + `ASF_SLOT_BITS;

    // Saturating bit counter step, shared by slot and frame counters
    function automatic logic [9:0] sat_inc(input logic [9:0] v);
        return (v == `ASF_CNT_SAT) ? v : v + `ASF_CNT_FIRST;
    endfunction

    // Link reset: asserts at once, releases on the bit clock
    logic [1:0] lrst_q;
    logic       rst_link_b;
    always_ff @(posedge bit_clock or negedge rst_b)
    begin
        if (!rst_b)
            lrst_q <= 2'h0;
        else
            lrst_q <= {lrst_q[0], 1'h1};
    end
    assign rst_link_b = lrst_q[1];

    // Link-side copy of the mode pins; a change counts once two stages agree
    logic [4:0] lcfg1_q, lcfg2_q, lcfg3_q, lcfg_q;
    always_ff @(posedge bit_clock or negedge rst_link_b)
    begin
        if (!rst_link_b)
        begin
            lcfg1_q <= 5'h01;
            lcfg2_q <= 5'h01;
            lcfg3_q <= 5'h01;
            lcfg_q  <= 5'h01;
        end
        else
        begin
            lcfg1_q <= {slot_mode, speed_select};
            lcfg2_q <= lcfg1_q;
            lcfg3_q <= lcfg2_q;
            if (lcfg2_q == lcfg3_q)
                lcfg_q <= lcfg3_q;
        end
    end

    logic [1:0]                l_slot;
    asf_speed_t                l_spd;
    asf_lstate_t               ls_q, ls_d;
    logic                      fc_q;
    logic [9:0]                pos_q, fcnt_q, idx_w, fcnt_d;
    logic [`ASF_WORD_BITS-1:0] sh_q, sh_d;
    logic                      tdm_w, rise_w, slot_edge_w, frame_edge_w;
    logic [3:0]                slot_w;
    logic                      take_w, busy_w, len_ok_w, mode_ok_w;

    // Frame boundaries are judged on the bit-clock sample, relying on a clean edge gap
    assign l_slot       = lcfg_q[4:3];
    assign l_spd        = asf_speed_decode(lcfg_q[2:0]);
    assign tdm_w        = l_slot != `ASF_SLOT_NORMAL;
    assign rise_w       = frame_clock & ~fc_q;
    assign slot_edge_w  = tdm_w ? rise_w : (frame_clock ^ fc_q);
    assign frame_edge_w = rise_w & (ls_q == ASF_LS_RUN);

    // Bit position within the phase, or within the whole frame when slotted; the boundary bit is bit zero
    assign idx_w  = slot_edge_w ? `ASF_CNT_ZERO : sat_inc(pos_q);
    assign fcnt_d = rise_w ? `ASF_CNT_FIRST : sat_inc(fcnt_q);
    assign sh_d   = {sh_q[`ASF_WORD_BITS-2:0], serial_audio_in};
    assign slot_w = tdm_w ? idx_w[8:5] : {3'h0, ~frame_clock};

    // Non-multiplexed phases deliver only their first word; shorter phases deliver none
    assign take_w = (ls_q == ASF_LS_RUN) && (idx_w[4:0] == `ASF_WORD_LAST)
                    && (tdm_w ? !idx_w[9] : (idx_w[9:5] == 5'h00));

    // Frame length and mode legality
    assign len_ok_w  = tdm_w ? (fcnt_q == asf_frame_bits(l_slot))
                             : (fcnt_q <= asf_ratio_limit(l_spd));
    assign mode_ok_w = asf_mode_legal(l_slot, l_spd);

    // Hunt for the first frame start before trusting any count
    always_comb
    begin
        case (ls_q)
            ASF_LS_SEEK: ls_d = rise_w ? ASF_LS_RUN : ASF_LS_SEEK;
            ASF_LS_RUN:  ls_d = ASF_LS_RUN;
            default:     ls_d = ASF_LS_SEEK;
        endcase
    end

    always_ff @(posedge bit_clock or negedge rst_link_b)
    begin
        if (!rst_link_b)
        begin
            ls_q   <= ASF_LS_SEEK;
            fc_q   <= 1'h0;
            pos_q  <= `ASF_CNT_ZERO;
            fcnt_q <= `ASF_CNT_ZERO;
            sh_q   <= '0;
        end
        else
        begin
            ls_q   <= ls_d;
            fc_q   <= frame_clock;
            pos_q  <= idx_w;
            fcnt_q <= fcnt_d;
            sh_q   <= sh_d;
        end
    end

    // Word handshake toward the system clock; a busy hold drops the word
    logic [`ASF_WORD_BITS-1:0] hold_data_q;
    logic [3:0]                hold_slot_q;
    logic                      req_q, ack1_q, ack2_q, ack_q, ovr_tg_q, frm_tg_q;
    logic                      ratio_bad_q, mode_bad_q;
    assign busy_w = req_q ^ ack2_q;

    always_ff @(posedge bit_clock or negedge rst_link_b)
    begin
        if (!rst_link_b)
        begin
            hold_data_q <= '0;
            hold_slot_q <= 4'h0;
            req_q       <= 1'h0;
            ovr_tg_q    <= 1'h0;
            ack1_q      <= 1'h0;
            ack2_q      <= 1'h0;
        end
        else
        begin
            ack1_q <= ack_q;
            ack2_q <= ack1_q;
            if (take_w && !busy_w)
            begin
                hold_data_q <= sh_d;
                hold_slot_q <= slot_w;
                req_q       <= ~req_q;
            end
            if (take_w && busy_w)
                ovr_tg_q <= ~ovr_tg_q;
        end
    end

    // Per-frame verdicts are levels that hold for a whole frame
    always_ff @(posedge bit_clock or negedge rst_link_b)
    begin
        if (!rst_link_b)
        begin
            ratio_bad_q <= 1'h0;
            mode_bad_q  <= 1'h0;
            frm_tg_q    <= 1'h0;
        end
        else if (frame_edge_w)
        begin
            ratio_bad_q <= ~len_ok_w;
            mode_bad_q  <= ~mode_ok_w;
            frm_tg_q    <= ~frm_tg_q;
        end
    end

    // System side: toggles and levels through two flops, a third for edges
    logic [2:0] t1_q, t2_q, t3_q;
    logic [1:0] v1_q, v2_q;
    logic [2:0] s1_q, s2_q, s3_q, sspd_q;
    logic       ev_word, ev_frm, ev_ovr;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            t1_q   <= 3'h0;
            t2_q   <= 3'h0;
            t3_q   <= 3'h0;
            v1_q   <= 2'h0;
            v2_q   <= 2'h0;
            s1_q   <= 3'h0;
            s2_q   <= 3'h0;
            s3_q   <= 3'h0;
            sspd_q <= 3'h0;
        end
        else
        begin
            t1_q <= {ovr_tg_q, frm_tg_q, req_q};
            t2_q <= t1_q;
            t3_q <= t2_q;
            v1_q <= {mode_bad_q, ratio_bad_q};
            v2_q <= v1_q;
            s1_q <= speed_select;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                sspd_q <= s3_q;
        end
    end
    assign ev_word = t2_q[0] ^ t3_q[0];
    assign ev_frm  = t2_q[1] ^ t3_q[1];
    assign ev_ovr  = t2_q[2] ^ t3_q[2];

    // Pending word waits for buffer room, then acknowledges the link
    logic pend_q, push_w, buf_ready;
    assign push_w = pend_q & buf_ready;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_q <= 1'h0;
            ack_q  <= 1'h0;
        end
        else
        begin
            pend_q <= ev_word | (pend_q & ~buf_ready);
            ack_q  <= ack_q ^ push_w;
        end
    end

    asf_buf2 #(
        .W (BW)
    ) u_buf (
        .clk       (sys_clk),
        .rst_b     (rst_b),
        .in_data   ({hold_slot_q, hold_data_q}),
        .in_valid  (pend_q),
        .in_ready  (buf_ready),
        .out_data  ({word_slot, word_data}),
        .out_valid (word_valid),
        .out_ready (word_ready)
    );

    // Frame period window follows the speed mode; a small slack absorbs crossing jitter
    asf_speed_t  s_spd;
    logic [15:0] lo_w, hi_w, per_q;
    logic        seen_q;
    assign s_spd = asf_speed_decode(sspd_q);
    assign lo_w  = (s_spd == ASF_SPD_QUAD) ? FR_MIN_QUAD - RATE_TOL :
                   (s_spd == ASF_SPD_DOUBLE) ? FR_MIN_DBL - RATE_TOL : FR_MIN_NORM - RATE_TOL;
    assign hi_w  = (s_spd == ASF_SPD_QUAD) ? FR_MAX_QUAD + RATE_TOL :
                   (s_spd == ASF_SPD_DOUBLE) ? FR_MAX_DBL + RATE_TOL : FR_MAX_NORM + RATE_TOL;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            per_q      <= 16'h0000;
            seen_q     <= 1'h0;
            rate_err_q <= 1'h0;
        end
        else if (ev_frm)
        begin
            per_q      <= 16'h0001;
            seen_q     <= 1'h1;
            rate_err_q <= seen_q & ((per_q < lo_w) | (per_q > hi_w));
        end
        else if (per_q != 16'hFFFF)
            per_q <= per_q + 16'h0001;
    end

    // Status outputs, all registered
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_start_q <= 1'h0;
            overrun_q     <= 1'h0;
            ratio_err_q   <= 1'h0;
            mode_err_q    <= 1'h0;
        end
        else
        begin
            frame_start_q <= ev_frm;
            overrun_q     <= ev_ovr;
            ratio_err_q   <= v2_q[0];
            mode_err_q    <= v2_q[1];
        end
    end

    // Checks on the link side
    non_tdm_ratio_a: assert property (@(posedge bit_clock) disable iff (!rst_link_b)
        frame_edge_w && !tdm_w && fcnt_q > asf_ratio_limit(l_spd) |=> ratio_bad_q)
        else $error("oversized non-multiplexed frame not flagged");
    frame_128_slots_len_a: assert property (@(posedge bit_clock) disable iff (!rst_link_b)
        frame_edge_w && l_slot == `ASF_SLOT_128 |=> ratio_bad_q == ($past(fcnt_q) != `ASF_FRAME_BITS_128))
        else $error("128-bit frame length verdict wrong");
    frame_256_slots_quad_a: assert property (@(posedge bit_clock) disable iff (!rst_link_b)
        frame_edge_w && l_slot == `ASF_SLOT_256 && l_spd == ASF_SPD_QUAD |=> mode_bad_q)
        else $error("quad speed with 256-bit frames not flagged");
    frame_512_slots_speed_a: assert property (@(posedge bit_clock) disable iff (!rst_link_b)
        frame_edge_w && l_slot == `ASF_SLOT_512 |=> mode_bad_q == ($past(l_spd) != ASF_SPD_NORMAL))
        else $error("512-bit frame speed verdict wrong");
    slot_origin_a: assert property (@(posedge bit_clock) disable iff (!rst_link_b)
        slot_edge_w ##1 !slot_edge_w |-> pos_q == `ASF_CNT_ZERO)
        else $error("bit count not restarted at frame boundary");
    bit_sample_a: assert property (@(posedge bit_clock) disable iff (!rst_link_b)
        take_w && !busy_w |=> hold_data_q[0] == $past(serial_audio_in) && hold_slot_q == $past(slot_w))
        else $error("slot word not taken on the rising edge");

    // Checks on the system side
    speed_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ev_frm && seen_q && s_spd == ASF_SPD_QUAD && per_q < FR_MIN_QUAD - RATE_TOL |=> rate_err_q)
        else $error("too fast frame at quad speed not flagged");
    // A stalled consumer may hold the word for any time, so only its loss is checked
    word_handoff_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (ev_word || (pend_q && !buf_ready)) |=> pend_q)
        else $error("crossed word lost before the buffer took it");

    frame_128_slots_ok_c:  cover property (@(posedge bit_clock) disable iff (!rst_link_b)
        frame_edge_w && l_slot == `ASF_SLOT_128 && len_ok_w);
    overrun_c:    cover property (@(posedge bit_clock) disable iff (!rst_link_b) take_w && busy_w);
    stall_c:      cover property (@(posedge sys_clk) disable iff (!rst_b) pend_q && !buf_ready);
    rate_err_c:   cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(rate_err_q));

endmodule

`default_nettype wire

// ===== asf_audio_src.sv
// Behavioural audio source that drives serial frames into the receiver
`timescale 1ns/10ps
`default_nettype none

module asf_audio_src
#(
    parameter realtime HALF_NS = 3.0
)
(
    output logic bit_clock,
    output logic frame_clock,
    output logic serial_audio_in
);
    // Link clock rests low between bursts, it never runs free
    initial
    begin
        bit_clock = 1'h0;
        frame_clock = 1'h0;
        serial_audio_in = 1'h0;
    end

    // Word carried in slot s of frame f
    function automatic logic [31:0] word_of(input int f, input int s);
        return {8'hA5, 8'(f), 8'(s), 8'h3C};
    endfunction

    // One bit period; lines move only while the clock is low
    task automatic tick(input logic fc, input logic d);
        frame_clock = fc;
        serial_audio_in = d;
        #(HALF_NS) bit_clock = 1'h1;
        #(HALF_NS) bit_clock = 1'h0;
    endtask

    // Idle bits, back-to-back frames, then one closing frame edge for the verdict
    task automatic send(input int nf, input int bits, input logic nm);
        int         h;
        int         sl;
        int         q;
        logic       d;
        logic [31:0] w;
        h = bits / 2;
        #1.7;
        repeat (8) tick(1'h0, ~serial_audio_in);
        for (int f = 0; f < nf; f++)
            for (int p = 0; p < bits; p++)
            begin
                sl = nm ? int'(p >= h) : p / 32;
                q = nm ? ((p >= h) ? p - h : p) : p % 32;
                w = word_of(f, sl);
                // Filler toggles so a stale bit never looks like data
                d = (q < 32) ? w[31 - q] : ~serial_audio_in;
                tick(p < h, d);
            end
        repeat (8) tick(1'h1, ~serial_audio_in);
        serial_audio_in = ~serial_audio_in;
    endtask
endmodule

`default_nettype wire

// ===== test_asf_frame_rx.sv
// Self-checking bench of the serial audio frame receiver
`timescale 1ns/10ps
`default_nettype none
`include "asf_regs.svh"

module test_asf_frame_rx;
    // Frame-period windows in system cycles, scaled down except the normal-speed maximum
    localparam int MIN_N = 16'h0096;
    localparam int MAX_N = `ASF_MAX_CYC(`ASF_FS_NORM_MIN_HZ);
    localparam int MIN_D = 16'h0064;
    localparam int MAX_D = 16'h01A4;
    localparam int MIN_Q = 16'h003C;
    localparam int MAX_Q = 16'h00C8;

    logic        sys_clk;
    logic        rst_b;
    logic        word_ready;
    logic [1:0]  slot_mode;
    logic [2:0]  speed_select;
    wire logic   bit_clock;
    wire logic   frame_clock;
    wire logic   serial_audio_in;
    logic [31:0] word_data;
    logic [3:0]  word_slot;
    logic        word_valid;
    logic        frame_start_q;
    logic        ratio_err_q;
    logic        mode_err_q;
    logic        rate_err_q;
    logic        overrun_q;
    int          bad_count = 0;
    int          n_checks = 0;
    int          ovr_seen = 0;
    int          frm_seen = 0;
    logic [35:0] got_q [$];

    asf_frame_rx #(
        .FR_MIN_NORM (16'h0096),
        .FR_MIN_DBL  (16'h0064),
        .FR_MAX_DBL  (16'h01A4),
        .FR_MIN_QUAD (16'h003C),
        .FR_MAX_QUAD (16'h00C8)
    ) dut_u (
        .sys_clk         (sys_clk),
        .rst_b           (rst_b),
        .bit_clock       (bit_clock),
        .frame_clock     (frame_clock),
        .serial_audio_in (serial_audio_in),
        .slot_mode       (slot_mode),
        .speed_select    (speed_select),
        .word_data       (word_data),
        .word_slot       (word_slot),
        .word_valid      (word_valid),
        .word_ready      (word_ready),
        .frame_start_q   (frame_start_q),
        .ratio_err_q     (ratio_err_q),
        .mode_err_q      (mode_err_q),
        .rate_err_q      (rate_err_q),
        .overrun_q       (overrun_q)
    );

    asf_audio_src src_u (
        .bit_clock       (bit_clock),
        .frame_clock     (frame_clock),
        .serial_audio_in (serial_audio_in)
    );

    always #2 sys_clk = ~sys_clk;

    // Collect accepted words and dropped-word pulses
    always @(posedge sys_clk)
    begin
        if (word_valid === 1'h1 && word_ready === 1'h1)
            got_q.push_back({word_slot, word_data});
        if (overrun_q === 1'h1)
            ovr_seen++;
        if (frame_start_q === 1'h1)
            frm_seen++;
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Modes change only while the link clock stands still
    task automatic burst(input logic [1:0] sm, input logic [2:0] sel, input int bits);
        @(posedge sys_clk);
        slot_mode <= sm;
        speed_select <= sel;
        got_q.delete();
        ovr_seen = 0;
        frm_seen = 0;
        src_u.send(2, bits, sm == `ASF_SLOT_NORMAL);
        repeat (40) @(posedge sys_clk);
        #1;
    endtask

    // Verdicts of the last frame, and the words of both frames unless a mode error is expected
    task automatic judge(input logic [1:0] sm, input logic [2:0] sel, input int bits,
                         input logic ratio_e, input logic mode_e);
        int cyc;
        int lo;
        int hi;
        int ns;
        int i;
        cyc = bits * 3 / 2;
        lo = sel[2] ? MIN_Q : (sel[1] ? MIN_D : MIN_N);
        hi = sel[2] ? MAX_Q : (sel[1] ? MAX_D : MAX_N);
        ns = (sm == `ASF_SLOT_NORMAL) ? ((bits / 2 >= 32) ? 2 : 0) : bits / 32;
        i = 0;
        check(36'(ratio_err_q), 36'(ratio_e));
        check(36'(mode_err_q), 36'(mode_e));
        check(36'(rate_err_q), 36'(cyc < lo || cyc > hi));
        check(36'(frm_seen), 36'h3);
        if (mode_e)
            return;
        check(36'(got_q.size()), 36'(2 * ns));
        for (int f = 0; f < 2; f++)
            for (int s = 0; s < ns; s++)
            begin
                if (i < got_q.size())
                    check(got_q[i], {4'(s), src_u.word_of(f, s)});
                i++;
            end
    endtask

    // Non-multiplexed ratio limits per speed, including select priority
    task automatic t_nonmux();
        logic [2:0] sel_a [10] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h6, 3'h4};
        int         bits_a [10] = '{256, 264, 32, 128, 136, 136, 64, 72, 72, 32};
        logic [0:9] rat = 10'b0100110110;
        for (int k = 0; k < 10; k++)
        begin
            burst(`ASF_SLOT_NORMAL, sel_a[k], bits_a[k]);
            judge(`ASF_SLOT_NORMAL, sel_a[k], bits_a[k], rat[k], 1'h0);
        end
    endtask

    // Slotted frames in every slot mode, legal and illegal speeds
    task automatic t_tdm();
        logic [1:0] sm_a [7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1};
        logic [2:0] sel_a [7] = '{3'h1, 3'h4, 3'h2, 3'h4, 3'h1, 3'h2, 3'h2};
        int         bits_a [7] = '{128, 128, 256, 256, 512, 512, 130};
        logic [0:6] rat = 7'b0000001;
        logic [0:6] mod = 7'b0001010;
        for (int k = 0; k < 7; k++)
        begin
            burst(sm_a[k], sel_a[k], bits_a[k]);
            judge(sm_a[k], sel_a[k], bits_a[k], rat[k], mod[k]);
        end
    endtask

    // Consumer stalls a whole burst, then drains the buffer empty
    task automatic t_overrun();
        @(posedge sys_clk);
        word_ready <= 1'h0;
        burst(`ASF_SLOT_128, 3'h2, 128);
        check(36'(word_valid), 36'h1);
        check(36'(ovr_seen != 0), 36'h1);
        @(posedge sys_clk);
        word_ready <= 1'h1;
        repeat (10) @(posedge sys_clk);
        #1;
        check((got_q.size() != 0) ? got_q[0] : 36'h0, {4'h0, src_u.word_of(0, 0)});
        check(36'(word_valid), 36'h0);
    endtask

    initial
    begin
        sys_clk = 1'h0;
        rst_b = 1'h0;
        word_ready = 1'h1;
        slot_mode = `ASF_SLOT_NORMAL;
        speed_select = 3'h1;
        // Link clock must tick while reset is held
        src_u.send(0, 0, 1'h1);
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'h1;
        // One aligning frame edge so every burst shows three frame starts
        src_u.send(0, 0, 1'h1);
        t_nonmux();
        t_tdm();
        t_overrun();
        end_of_test();
    end

    // Cuts a hang well beyond the expected run length
    initial
    begin
        #400000;
        bad_count++;
        end_of_test();
    end
endmodule

`default_nettype wire
